// File: vcf_pkg.sv
// package with register map, handshake modes and timing constants for the serial bridge
package vcf_pkg;
    // apb register byte offsets
    localparam logic [11:0] VCF_OFF_CTRL = 12'h000;
    localparam logic [11:0] VCF_OFF_BAUD = 12'h004;
    localparam logic [11:0] VCF_OFF_TXD = 12'h008;
    localparam logic [11:0] VCF_OFF_RXD = 12'h00c;
    localparam logic [11:0] VCF_OFF_STAT = 12'h010;
    // ctrl field positions
    localparam int VCF_CTRL_HS_LO = 0;
    localparam int VCF_CTRL_HS_W = 2;
    // status field positions
    localparam int VCF_ST_TXFULL = 0;
    localparam int VCF_ST_RXVALID = 1;
    localparam int VCF_ST_TXBUSY = 2;
    localparam int VCF_ST_RXFULL = 3;
    localparam int VCF_ST_FRERR = 4;
    localparam int VCF_ST_OVERRUN = 5;
    localparam int VCF_ST_CTSOUT = 6;
    localparam int VCF_ST_RTSIN = 7;
    localparam int VCF_ST_ENABLE = 8;
    // clock and baud figures
    localparam int VCF_CLK_HZ = 200000000;
    localparam int VCF_BAUD_DEF = 115200;
    localparam int VCF_BAUD_MIN = 9600;
    localparam int VCF_BAUD_MAX = 921600;
    localparam int VCF_OVS = 16;
    localparam int VCF_DATA_BITS = 8;
    localparam int VCF_FIFO_DEPTH = 8;
    // divider reload for one oversample tick, minus one
    localparam logic [15:0] VCF_DIV_DEF = 16'(VCF_CLK_HZ / (VCF_BAUD_DEF * VCF_OVS) - 1);
    // rounded up so the fastest setting never runs above the top rate
    localparam logic [15:0] VCF_DIV_MIN =
        16'((VCF_CLK_HZ + VCF_BAUD_MAX * VCF_OVS - 1) / (VCF_BAUD_MAX * VCF_OVS) - 1);
    localparam logic [15:0] VCF_DIV_MAX = 16'(VCF_CLK_HZ / (VCF_BAUD_MIN * VCF_OVS) - 1);
    localparam logic [3:0] VCF_OVS_LAST = 4'(VCF_OVS - 1);
    localparam logic [3:0] VCF_OVS_MID = 4'(VCF_OVS / 2 - 1);
    localparam logic [3:0] VCF_BIT_LAST = 4'(VCF_DATA_BITS - 1);

    // handshake modes
    typedef enum logic [1:0] {
        VCF_HS_DISABLED = 2'b00,
        VCF_HS_RTS = 2'b01,
        VCF_HS_CTS = 2'b10,
        VCF_HS_RTSCTS = 2'b11
    } vcf_hs_t;

    typedef enum logic [1:0] {
        VCF_TX_IDLE = 2'b00,
        VCF_TX_START = 2'b01,
        VCF_TX_DATA = 2'b10,
        VCF_TX_STOP = 2'b11
    } vcf_txst_t;

    typedef enum logic [1:0] {
        VCF_RX_IDLE = 2'b00,
        VCF_RX_START = 2'b01,
        VCF_RX_DATA = 2'b10,
        VCF_RX_STOP = 2'b11
    } vcf_rxst_t;
endpackage

// File: vcf_stream_if.sv
// valid/ready byte stream between the bridge and its fifo
`timescale 1ns/100ps
`default_nettype none
interface vcf_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: vcf_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module vcf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    vcf_stream_if.snk in_s,
    vcf_stream_if.src out_s,
    output logic full,
    output logic empty
);
    import vcf_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // handshakes; full stalls the writer, empty stalls the reader
    assign full = (cnt_q == CNT_FULL);
    assign empty = (cnt_q == '0);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem_q[rd_q];
    assign push = in_s.valid && !full;
    assign pop = out_s.ready && !empty;

    // pointer and count next state
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage carries no reset, only data
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end
endmodule
`default_nettype wire

// File: vcf_bridge.sv
// serial bridge with rts/cts handshake, apb registers and fifos on both paths
// Summary of operation
// - after reset the link runs at 115200 baud, 8 data bits, no parity, one stop bit, handshake disabled.
// - software can set bit rates from about 9600 up to about 892857 (divider 1301 down to 13) through the baud divider register.
// - clear-to-send toward the target drops while the receive buffer is full and rises when room returns.
// - with receive-side flow control on, the bridge starts no character while the target holds request-to-send low.
// - a character already on the line is always finished; the target must take one more after dropping its request.
// - in disabled mode clear-to-send is not driven and request-to-send is ignored.
// - in rts mode clear-to-send is driven for hold-off and request-to-send is ignored.
// - in cts mode clear-to-send is not driven and sending is gated by request-to-send.
// - in rtscts mode clear-to-send is driven and sending is gated by request-to-send.
// - with receive-side flow control off the level of request-to-send is disregarded.
// - characters only start, in either direction, while the interface enable is active.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module vcf_bridge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vcom_enable,
    input wire logic target_txd,
    output logic target_rxd,
    output logic target_cts_o,
    output logic target_cts_oe,
    input wire logic target_rts
);
    import vcf_pkg::*;

    // register state
    vcf_hs_t hs_q, hs_d;
    logic [15:0] div_q, div_d;
    logic frerr_q, frerr_d, ovr_q, ovr_d;
    logic [31:0] prdata_q, prdata_d;

    // baud tick divider
    logic [15:0] bcnt_q, bcnt_d;
    logic tick;

    // transmitter
    vcf_txst_t txs_q, txs_d;
    logic [3:0] txo_q, txo_d, txb_q, txb_d;
    logic [7:0] txsh_q, txsh_d;
    logic txline_q, txline_d;

    // receiver
    vcf_rxst_t rxs_q, rxs_d;
    logic [3:0] rxo_q, rxo_d, rxb_q, rxb_d;
    logic [7:0] rxsh_q, rxsh_d;

    vcf_stream_if #(.W(VCF_DATA_BITS)) txw ();
    vcf_stream_if #(.W(VCF_DATA_BITS)) txr ();
    vcf_stream_if #(.W(VCF_DATA_BITS)) rxw ();
    vcf_stream_if #(.W(VCF_DATA_BITS)) rxr ();
    logic tx_full, tx_empty, rx_full, rx_empty;

    logic wr_en, rd_en, setup_ok;
    logic gate_on_rts, drive_cts, tx_allowed;

    // decodes a handshake mode into its two switches
    function automatic logic mode_drives_cts(input vcf_hs_t m);
        return (m == VCF_HS_RTS) || (m == VCF_HS_RTSCTS);
    endfunction
    function automatic logic mode_gates_tx(input vcf_hs_t m);
        return (m == VCF_HS_CTS) || (m == VCF_HS_RTSCTS);
    endfunction

    // fifos: bus writes fill tx path, line receiver fills rx path
    vcf_fifo #(.WIDTH(VCF_DATA_BITS), .DEPTH(VCF_FIFO_DEPTH)) u_txf (
        .pclk(pclk), .presetn(presetn), .in_s(txw), .out_s(txr), .full(tx_full), .empty(tx_empty)
    );
    vcf_fifo #(.WIDTH(VCF_DATA_BITS), .DEPTH(VCF_FIFO_DEPTH)) u_rxf (
        .pclk(pclk), .presetn(presetn), .in_s(rxw), .out_s(rxr), .full(rx_full), .empty(rx_empty)
    );

    // apb is zero wait state: access phase completes at once
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign setup_ok = psel && !penable;
    assign prdata = prdata_q;
    assign pslverr = psel && penable && !((paddr == VCF_OFF_CTRL) || (paddr == VCF_OFF_BAUD)
        || (paddr == VCF_OFF_TXD) || (paddr == VCF_OFF_RXD) || (paddr == VCF_OFF_STAT));
    // writes to a full tx fifo are dropped and flagged through txfull
    assign txw.valid = wr_en && (paddr == VCF_OFF_TXD);
    assign txw.data = pwdata[7:0];
    assign rxr.ready = rd_en && (paddr == VCF_OFF_RXD);

    // handshake switches
    assign drive_cts = mode_drives_cts(hs_q);
    assign gate_on_rts = mode_gates_tx(hs_q);
    // a stuck-low request stalls sending forever; the target owns that pin
    assign tx_allowed = vcom_enable && (!gate_on_rts || target_rts);
    // cts low only while rx buffer cannot take more
    assign target_cts_o = !rx_full;
    assign target_cts_oe = drive_cts;
    // line idles high when not enabled
    assign target_rxd = txline_q;

    // register file next values
    always_comb begin
        hs_d = hs_q;
        div_d = div_q;
        frerr_d = frerr_q;
        ovr_d = ovr_q;
        prdata_d = prdata_q;
        if (wr_en && paddr == VCF_OFF_CTRL) begin
            hs_d = vcf_hs_t'(pwdata[VCF_CTRL_HS_LO +: VCF_CTRL_HS_W]);
        end
        if (wr_en && paddr == VCF_OFF_BAUD) begin
            // clamp keeps the rate inside 9600..921600
            if (pwdata[15:0] < VCF_DIV_MIN) begin
                div_d = VCF_DIV_MIN;
            end else if (pwdata[31:16] != '0 || pwdata[15:0] > VCF_DIV_MAX) begin
                div_d = VCF_DIV_MAX;
            end else begin
                div_d = pwdata[15:0];
            end
        end
        // status reads clear errors; a new error in the same cycle wins
        if (rd_en && paddr == VCF_OFF_STAT) begin
            frerr_d = 1'b0;
            ovr_d = 1'b0;
        end
        if (rxs_q == VCF_RX_STOP && tick && rxo_q == VCF_OVS_LAST) begin
            if (!target_txd) begin
                frerr_d = 1'b1;
            end else if (rx_full) begin
                ovr_d = 1'b1;
            end
        end
        if (setup_ok && !pwrite) begin
            prdata_d = '0;
            unique case (paddr)
                VCF_OFF_CTRL: prdata_d[VCF_CTRL_HS_LO +: VCF_CTRL_HS_W] = hs_q;
                VCF_OFF_BAUD: prdata_d[15:0] = div_q;
                VCF_OFF_RXD: prdata_d[7:0] = rx_empty ? 8'h00 : rxr.data;
                VCF_OFF_STAT: begin
                    prdata_d[VCF_ST_TXFULL] = tx_full;
                    prdata_d[VCF_ST_RXVALID] = !rx_empty;
                    prdata_d[VCF_ST_TXBUSY] = (txs_q != VCF_TX_IDLE);
                    prdata_d[VCF_ST_RXFULL] = rx_full;
                    prdata_d[VCF_ST_FRERR] = frerr_q;
                    prdata_d[VCF_ST_OVERRUN] = ovr_q;
                    prdata_d[VCF_ST_CTSOUT] = target_cts_o;
                    prdata_d[VCF_ST_RTSIN] = target_rts;
                    prdata_d[VCF_ST_ENABLE] = vcom_enable;
                end
                default: prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q <= VCF_HS_DISABLED;
            div_q <= VCF_DIV_DEF;
            frerr_q <= 1'b0;
            ovr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            hs_q <= hs_d;
            div_q <= div_d;
            frerr_q <= frerr_d;
            ovr_q <= ovr_d;
            prdata_q <= prdata_d;
        end
    end

    // oversample tick divider, one-cycle enable
    assign tick = (bcnt_q == '0);
    always_comb begin
        bcnt_d = tick ? div_q : bcnt_q - 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= '0;
        end else begin
            bcnt_q <= bcnt_d;
        end
    end

    // transmitter toward the target
    always_comb begin
        txs_d = txs_q;
        txo_d = txo_q;
        txb_d = txb_q;
        txsh_d = txsh_q;
        txline_d = txline_q;
        txr.ready = 1'b0;
        if (tick) begin
            txo_d = txo_q + 1'b1;
        end
        unique case (txs_q)
            VCF_TX_IDLE: begin
                txline_d = 1'b1;
                // new characters start only at a gap, never cut mid-frame
                if (tick && !tx_empty && tx_allowed) begin
                    txr.ready = 1'b1;
                    txsh_d = txr.data;
                    txline_d = 1'b0;
                    txo_d = '0;
                    txs_d = VCF_TX_START;
                end
            end
            VCF_TX_START: begin
                if (tick && txo_q == VCF_OVS_LAST) begin
                    txline_d = txsh_q[0];
                    txb_d = '0;
                    txs_d = VCF_TX_DATA;
                end
            end
            VCF_TX_DATA: begin
                if (tick && txo_q == VCF_OVS_LAST) begin
                    if (txb_q == VCF_BIT_LAST) begin
                        txline_d = 1'b1;
                        txs_d = VCF_TX_STOP;
                    end else begin
                        txsh_d = {1'b0, txsh_q[7:1]};
                        txline_d = txsh_q[1];
                        txb_d = txb_q + 1'b1;
                    end
                end
            end
            VCF_TX_STOP: begin
                if (tick && txo_q == VCF_OVS_LAST) begin
                    txs_d = VCF_TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txs_q <= VCF_TX_IDLE;
            txo_q <= '0;
            txb_q <= '0;
            txsh_q <= '0;
            txline_q <= 1'b1;
        end else begin
            txs_q <= txs_d;
            txo_q <= txo_d;
            txb_q <= txb_d;
            txsh_q <= txsh_d;
            txline_q <= txline_d;
        end
    end

    // receiver from the target, samples mid-bit
    always_comb begin
        rxs_d = rxs_q;
        rxo_d = rxo_q;
        rxb_d = rxb_q;
        rxsh_d = rxsh_q;
        rxw.valid = 1'b0;
        rxw.data = rxsh_q;
        if (tick) begin
            rxo_d = rxo_q + 1'b1;
        end
        unique case (rxs_q)
            VCF_RX_IDLE: begin
                if (tick && vcom_enable && !target_txd) begin
                    rxo_d = '0;
                    rxs_d = VCF_RX_START;
                end
            end
            VCF_RX_START: begin
                if (tick && rxo_q == VCF_OVS_MID) begin
                    // a glitch shorter than half a bit is no start
                    rxs_d = target_txd ? VCF_RX_IDLE : VCF_RX_DATA;
                    rxo_d = '0;
                    rxb_d = '0;
                end
            end
            VCF_RX_DATA: begin
                if (tick && rxo_q == VCF_OVS_LAST) begin
                    rxsh_d = {target_txd, rxsh_q[7:1]};
                    rxb_d = rxb_q + 1'b1;
                    if (rxb_q == VCF_BIT_LAST) begin
                        rxs_d = VCF_RX_STOP;
                        rxo_d = '0;
                    end
                end
            end
            VCF_RX_STOP: begin
                // a full bit after the last data sample lands mid stop bit
                if (tick && rxo_q == VCF_OVS_LAST) begin
                    // good stop bit pushes; a full fifo drops the byte as overrun
                    rxw.valid = target_txd;
                    rxs_d = VCF_RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxs_q <= VCF_RX_IDLE;
            rxo_q <= '0;
            rxb_q <= '0;
            rxsh_q <= '0;
        end else begin
            rxs_q <= rxs_d;
            rxo_q <= rxo_d;
            rxb_q <= rxb_d;
            rxsh_q <= rxsh_d;
        end
    end
endmodule
`default_nettype wire

// File: vcf_bridge_checker.sv
// concurrent checks on the serial bridge ports
`timescale 1ns/100ps
`default_nettype none
module vcf_bridge_checker
    import vcf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic vcom_enable,
    input wire logic target_rxd,
    input wire logic target_cts_o,
    input wire logic target_cts_oe,
    input wire logic target_rts
);
    logic [1:0] mode_q, mode_d;
    logic [15:0] div_q, div_d;
    logic [31:0] fcnt_q, fcnt_d, low_q, low_d, bitc;
    logic wr, rd_rxd, fall;
    // shadow of mode and divider, frame position and low-run length
    assign wr = psel && penable && pwrite;
    assign rd_rxd = psel && !pwrite && paddr == VCF_OFF_RXD;
    assign bitc = 32'(VCF_OVS) * (32'(div_q) + 32'h1);
    assign fall = !target_rxd && low_q == 32'h0 && fcnt_q == 32'h0;
    always_comb begin
        mode_d = mode_q;
        div_d = div_q;
        if (wr && paddr == VCF_OFF_CTRL) begin
            mode_d = pwdata[1:0];
        end
        // divider is clamped, so the shadow clamps too
        if (wr && paddr == VCF_OFF_BAUD) begin
            if (pwdata[15:0] < VCF_DIV_MIN) begin
                div_d = VCF_DIV_MIN;
            end else if (pwdata[31:16] != 16'h0 || pwdata[15:0] > VCF_DIV_MAX) begin
                div_d = VCF_DIV_MAX;
            end else begin
                div_d = pwdata[15:0];
            end
        end
        low_d = target_rxd ? 32'h0 : low_q + 32'h1;
        fcnt_d = fall ? 32'd10 * bitc - 32'h1 : (fcnt_q != 32'h0 ? fcnt_q - 32'h1 : 32'h0);
    end
    // registers of the shadow state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            div_q <= VCF_DIV_DEF;
            fcnt_q <= 32'h0;
            low_q <= 32'h0;
        end else begin
            mode_q <= mode_d;
            div_q <= div_d;
            fcnt_q <= fcnt_d;
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence frame_begin_s;
        fall;
    endsequence
    sequence gated_begin_s;
        frame_begin_s ##0 mode_q[1];
    endsequence
    a_cts_undriven: assert property ($stable(mode_q) && !mode_q[0] |-> !target_cts_oe)
        else $error("cts driven in a mode that leaves it free");
    a_cts_driven: assert property ($stable(mode_q) && mode_q[0] |-> target_cts_oe)
        else $error("cts not driven in a hold-off mode");
    a_start_low: assert property (fcnt_q > 32'd9 * bitc |-> !target_rxd)
        else $error("start bit not low for a whole bit");
    a_stop_high: assert property (fcnt_q != 32'h0 && fcnt_q <= bitc |-> target_rxd)
        else $error("stop bit not high");
    a_bit_length: assert property ($rose(target_rxd) |-> low_q % bitc == 32'h0)
        else $error("low run not a whole number of bits");
    a_start_gated: assert property (gated_begin_s |-> $past(target_rts) || $past(target_rts, 2))
        else $error("frame started with rts low");
    a_enable_gate: assert property (frame_begin_s |-> $past(vcom_enable) || $past(vcom_enable, 2))
        else $error("frame started while disabled");
    a_cts_rise_pop: assert property ($rose(target_cts_o) |-> $past(rd_rxd) || $past(rd_rxd, 2))
        else $error("cts rose without a receive pop");
    a_unmapped_err: assert property (psel && penable && paddr > VCF_OFF_STAT |-> pslverr)
        else $error("unmapped access without error");
endmodule
`default_nettype wire

// File: vcf_target_model.sv
// behavioural target uart with rts/cts handshake
`timescale 1ns/100ps
`default_nettype none
module vcf_target_model #(parameter int BIT = 256) (
    input wire logic pclk,
    input wire logic rxd,
    input wire logic cts,
    input wire logic cts_oe,
    input wire logic hold,
    output logic txd,
    output logic rts,
    output logic got,
    output logic [7:0] byte_q
);
    // rts is always driven, low while the bench holds data off
    assign rts = !hold;
    initial begin
        txd = 1'b1;
        got = 1'b0;
        byte_q = 8'h00;
    end
    // one 8n1 frame; only started while cts allows it
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (cts_oe && !cts) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            txd <= f[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask
    // receiver samples mid-bit; a bad stop bit yields no byte
    initial begin : rx_loop
        logic [7:0] sh;
        forever begin
            @(negedge rxd);
            repeat (BIT / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge pclk);
                sh[i] = rxd;
            end
            repeat (BIT) @(posedge pclk);
            if (rxd === 1'b1) begin
                byte_q <= sh;
                got <= 1'b1;
                @(posedge pclk);
                got <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb_vcf_bridge.sv
// testbench for the serial bridge: apb driver, target model, scoreboards
`timescale 1ns/100ps
`default_nettype none
module tb_vcf_bridge;
    import vcf_pkg::*;
    localparam int DIV = 15;
    localparam int BIT = 16 * (DIV + 1);
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic vcom_enable = 1'b1;
    logic hold = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, target_txd, target_rxd, target_cts_o, target_cts_oe, target_rts, got;
    logic [7:0] rx_byte;
    logic [32:0] cur;
    logic [32:0] exp_q[$];
    logic [7:0] tx_q[$];
    logic [7:0] rx_exp[9];
    int mismatches = 0;
    int checked = 0;

    // 200 mhz clock
    always #2.5 pclk = !pclk;

    vcf_bridge u_vcf_bridge (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vcom_enable(vcom_enable), .target_txd(target_txd), .target_rxd(target_rxd),
        .target_cts_o(target_cts_o), .target_cts_oe(target_cts_oe), .target_rts(target_rts));
    vcf_target_model #(.BIT(BIT)) u_vcf_target_model (.pclk(pclk), .rxd(target_rxd), .cts(target_cts_o),
        .cts_oe(target_cts_oe), .hold(hold), .txd(target_txd), .rts(target_rts), .got(got), .byte_q(rx_byte));

    task automatic fail(input string m);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic c, input string m);
        checked++;
        if (c !== 1'b1) fail(m);
    endtask
    // one apb transfer; the answer is judged by the monitor below
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic send_tx(input logic [7:0] b);
        tx_q.push_back(b);
        apb(1'b1, VCF_OFF_TXD, {24'h0, b}, 33'h0);
    endtask
    // bounded wait until the target has taken every queued byte
    task automatic drain();
        for (int i = 0; i < 30 * BIT && tx_q.size() != 0; i++) @(posedge pclk);
        chk(tx_q.size() == 0, "bytes not delivered");
    endtask
    task automatic end_of_test();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // apb answers against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            cur = exp_q.pop_front();
            checked++;
            if (pslverr !== cur[32] || (!pwrite && prdata !== cur[31:0])) fail("apb answer differs");
        end
    end
    // bytes seen by the target against what was written
    always @(posedge pclk) begin
        if (got) begin
            checked++;
            if (tx_q.size() == 0 || rx_byte !== tx_q.pop_front()) fail("byte at target differs");
        end
    end
    // watchdog sized well above the roughly 52k cycles the tests need
    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'hc46f));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(target_rxd === 1'b1 && target_cts_oe === 1'b0, "pins after reset");
        apb(1'b0, VCF_OFF_CTRL, 32'h0, 33'h0);
        apb(1'b0, VCF_OFF_BAUD, 32'h0, {17'h0, VCF_DIV_DEF});
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h020, 32'h1, {1'b1, 32'h0});
        apb(1'b1, VCF_OFF_BAUD, 32'h1, 33'h0);
        apb(1'b0, VCF_OFF_BAUD, 32'h0, {17'h0, VCF_DIV_MIN});
        apb(1'b1, VCF_OFF_BAUD, 32'(DIV), 33'h0);
        apb(1'b0, VCF_OFF_BAUD, 32'h0, 33'(DIV));
        // disabled mode sends although rts is low
        repeat (2) send_tx(8'($urandom()));
        drain();
        vcom_enable <= 1'b0;
        send_tx(8'($urandom()));
        repeat (15 * BIT) @(posedge pclk);
        chk(tx_q.size() == 1 && target_rxd === 1'b1, "sent while disabled");
        vcom_enable <= 1'b1;
        drain();
        apb(1'b1, VCF_OFF_CTRL, 32'h2, 33'h0);
        send_tx(8'($urandom()));
        repeat (15 * BIT) @(posedge pclk);
        chk(tx_q.size() == 1 && target_cts_oe === 1'b0, "cts mode gating");
        hold <= 1'b0;
        drain();
        // drop rts in mid frame: that frame ends, the next waits
        apb(1'b1, VCF_OFF_CTRL, 32'h3, 33'h0);
        repeat (2) send_tx(8'($urandom()));
        while (target_rxd === 1'b1) @(posedge pclk);
        hold <= 1'b1;
        for (int i = 0; i < 12 * BIT && tx_q.size() > 1; i++) @(posedge pclk);
        repeat (15 * BIT) @(posedge pclk);
        chk(tx_q.size() == 1 && target_cts_oe === 1'b1, "rtscts gating");
        hold <= 1'b0;
        drain();
        apb(1'b1, VCF_OFF_CTRL, 32'h1, 33'h0);
        hold <= 1'b1;
        send_tx(8'($urandom()));
        drain();
        // nine bytes from the target: eight fill the receive fifo and one read reopens cts before the ninth starts
        foreach (rx_exp[i]) rx_exp[i] = 8'($urandom());
        fork
            foreach (rx_exp[i]) u_vcf_target_model.send(rx_exp[i]);
        join_none
        for (int i = 0; i < 100 * BIT && target_cts_o !== 1'b0; i++) @(posedge pclk);
        apb(1'b0, VCF_OFF_STAT, 32'h0, 33'h10a);
        apb(1'b0, VCF_OFF_RXD, 32'h0, {25'h0, rx_exp[0]});
        wait fork;
        for (int i = 1; i < 9; i++) apb(1'b0, VCF_OFF_RXD, 32'h0, {25'h0, rx_exp[i]});
        apb(1'b0, VCF_OFF_RXD, 32'h0, 33'h0);
        apb(1'b0, VCF_OFF_STAT, 32'h0, 33'h140);
        chk(exp_q.size() == 0 && tx_q.size() == 0, "results left over");
        end_of_test();
    end
endmodule
bind vcf_bridge vcf_bridge_checker u_vcf_bridge_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .vcom_enable(vcom_enable), .target_rxd(target_rxd), .target_cts_o(target_cts_o),
    .target_cts_oe(target_cts_oe), .target_rts(target_rts));
`default_nettype wire
